// *** core/msled_driver.sv ***
// Status LED driver with APB control registers
// ********************
// Behaviour
// ********************
`timescale 1ns/1ps
`include "msled_params.svh"
module msled_driver (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] eth_link,
  input wire logic [1:0] eth_activity,
  input wire logic [1:0] motor_running,
  input wire logic [1:0] motor_start,
  input wire logic [1:0] motor_ilimit,
  input wire logic [1:0] motor_disconnected,
  input wire logic [1:0] motor_overheat,
  input wire logic [1:0] motor_overload,
  input wire logic [1:0] motor_short,
  input wire logic supply_out_of_range,
  input wire logic supply_below_10v,
  output logic [1:0] eth_led,
  output logic [5:0] motor_led,
  output logic [2:0] status_led,
  output logic [1:0] start_window,
  output logic [15:0] start_ilimit
);
  // ********************
  // Shared timebase
  // ********************
  logic [24:0] blink_cnt;
  logic [24:0] flash_cnt;
  logic [24:0] slow_cnt;
  logic [15:0] ms_cnt;
  logic blink_ph, flash_ph, slow_ph, ms_tick;
  logic [24:0] next_blink_cnt, next_flash_cnt, next_slow_cnt;
  logic [15:0] next_ms_cnt;
  logic next_blink_ph, next_flash_ph, next_slow_ph;

  // One counter set for every LED keeps equal cadences in phase
  always_comb begin
    next_blink_cnt = blink_cnt + 25'h000_0001;
    next_blink_ph = blink_ph;
    if (blink_cnt == 25'(`MSLED_BLINK_HALF - 1)) begin
      next_blink_cnt = 25'h000_0000;
      next_blink_ph = !blink_ph;
    end
    next_flash_cnt = flash_cnt + 25'h000_0001;
    next_flash_ph = flash_ph;
    if (flash_cnt == 25'(`MSLED_FLASH_HALF - 1)) begin
      next_flash_cnt = 25'h000_0000;
      next_flash_ph = !flash_ph;
    end
    next_slow_cnt = slow_cnt + 25'h000_0001;
    next_slow_ph = slow_ph;
    if (slow_cnt == 25'(`MSLED_SLOW_HALF - 1)) begin
      next_slow_cnt = 25'h000_0000;
      next_slow_ph = !slow_ph;
    end
    next_ms_cnt = ms_cnt + 16'h0001;
    if (ms_cnt == 16'(`MSLED_MS_CYCLES - 1)) begin
      next_ms_cnt = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 25'h000_0000;
      flash_cnt <= 25'h000_0000;
      slow_cnt <= 25'h000_0000;
      ms_cnt <= 16'h0000;
      blink_ph <= 1'b0;
      flash_ph <= 1'b0;
      slow_ph <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      flash_cnt <= next_flash_cnt;
      slow_cnt <= next_slow_cnt;
      ms_cnt <= next_ms_cnt;
      blink_ph <= next_blink_ph;
      flash_ph <= next_flash_ph;
      slow_ph <= next_slow_ph;
    end
  end

  assign ms_tick = (ms_cnt == 16'(`MSLED_MS_CYCLES - 1));

  // ********************
  // APB registers
  // ********************
  logic [2:0] mstate;
  logic booting, discovery;
  logic [3:0] mtypes;
  logic [2:0] next_mstate;
  logic next_booting, next_discovery;
  logic [3:0] next_mtypes;
  logic wr_en, rd_en, addr_ok;
  logic [31:0] next_prdata;

  assign wr_en = psel && penable && pwrite;
  // Read data loads in setup so it stands at the access edge
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `MSLED_REG_CTRL) || (paddr == `MSLED_REG_MOTOR)
    || (paddr == `MSLED_REG_STATUS) || (paddr == `MSLED_REG_LEDS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    next_mstate = mstate;
    next_booting = booting;
    next_discovery = discovery;
    next_mtypes = mtypes;
    if (wr_en && paddr == `MSLED_REG_CTRL) begin
      next_mstate = pwdata[`MSLED_CTRL_MS_LSB +: 3];
      next_booting = pwdata[`MSLED_CTRL_BOOT];
      next_discovery = pwdata[`MSLED_CTRL_DISC];
    end
    if (wr_en && paddr == `MSLED_REG_MOTOR) begin
      next_mtypes = {pwdata[`MSLED_CTRL_MT1_LSB +: 2], pwdata[`MSLED_CTRL_MT0_LSB +: 2]};
    end
    next_prdata = prdata;
    if (rd_en) begin
      case (paddr)
        `MSLED_REG_CTRL: next_prdata = {27'h000_0000, discovery, booting, mstate};
        `MSLED_REG_MOTOR: next_prdata = {20'h0_0000, mtypes[3:2], mtypes[1:0], 8'h00};
        `MSLED_REG_STATUS: next_prdata = {16'h0000, start_ilimit};
        `MSLED_REG_LEDS: next_prdata = {19'h0_0000, start_window, status_led, motor_led,
          eth_led};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate <= 3'b000;
      booting <= 1'b1;
      discovery <= 1'b0;
      mtypes <= 4'h0;
      prdata <= 32'h0000_0000;
    end else begin
      mstate <= next_mstate;
      booting <= next_booting;
      discovery <= next_discovery;
      mtypes <= next_mtypes;
      prdata <= next_prdata;
    end
  end

  // ********************
  // Start windows
  // ********************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_port
      msled_start_window u_win (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick),
        .motor_start(motor_start[g]),
        .mtype(msled_pkg::msled_mtype_t'(mtypes[2*g +: 2])),
        .in_window(start_window[g]),
        .ilimit(start_ilimit[8*g +: 8])
      );
    end
  endgenerate

  // ********************
  // LED patterns
  // ********************
  logic [1:0] next_eth_led;
  logic [5:0] next_motor_led;
  logic [2:0] next_status_led;
  msled_pkg::msled_colour_t mc;

  always_comb begin
    next_eth_led = 2'b00;
    next_motor_led = 6'h00;
    mc = msled_pkg::MSLED_OFF;
    for (int i = 0; i < 2; i++) begin
      next_eth_led[i] = eth_link[i] && !(eth_activity[i] && blink_ph);
      if (discovery) begin
        mc = slow_ph ? msled_pkg::MSLED_RED : msled_pkg::MSLED_OFF;
      end else if (booting) begin
        mc = msled_pkg::MSLED_AMBER;
      end else if (motor_short[i] || supply_below_10v) begin
        mc = flash_ph ? msled_pkg::MSLED_RED : msled_pkg::MSLED_OFF;
      end else if (motor_overload[i]) begin
        mc = blink_ph ? msled_pkg::MSLED_RED : msled_pkg::MSLED_OFF;
      end else if (supply_out_of_range) begin
        mc = msled_pkg::MSLED_RED;
      end else if (motor_running[i] ? motor_ilimit[i]
                   : (motor_disconnected[i] || motor_overheat[i])) begin
        mc = msled_pkg::MSLED_RED;
      end else if (motor_running[i]) begin
        mc = msled_pkg::MSLED_GREEN;
      end else begin
        mc = msled_pkg::MSLED_OFF;
      end
      next_motor_led[3*i +: 3] = mc;
    end
    next_status_led = msled_pkg::MSLED_OFF;
    if (discovery) begin
      next_status_led = slow_ph ? msled_pkg::MSLED_RED : msled_pkg::MSLED_OFF;
    end else begin
      case (mstate)
        msled_pkg::MSLED_MS_TASKS: next_status_led = blink_ph ? msled_pkg::MSLED_RED
          : msled_pkg::MSLED_OFF;
        msled_pkg::MSLED_MS_READY: next_status_led = blink_ph ? msled_pkg::MSLED_GREEN
          : msled_pkg::MSLED_OFF;
        // Green flash overlays the red blink; red bit follows blink
        msled_pkg::MSLED_MS_FAILSAFE: next_status_led = {1'b0, blink_ph, flash_ph};
        msled_pkg::MSLED_MS_AUTOCFG: next_status_led = flash_ph ? msled_pkg::MSLED_RED
          : msled_pkg::MSLED_OFF;
        msled_pkg::MSLED_MS_PEERLOST, msled_pkg::MSLED_MS_FWCHECK:
          next_status_led = blink_ph ? msled_pkg::MSLED_AMBER : msled_pkg::MSLED_OFF;
        msled_pkg::MSLED_MS_FWWRITE: next_status_led = msled_pkg::MSLED_AMBER;
        default: next_status_led = msled_pkg::MSLED_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eth_led <= 2'b00;
      motor_led <= 6'h00;
      status_led <= 3'b000;
    end else begin
      eth_led <= next_eth_led;
      motor_led <= next_motor_led;
      status_led <= next_status_led;
    end
  end

  // ********************
  // Checks
  // ********************
  a_blink_half: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(blink_ph) |-> blink_cnt == 25'h000_0000)
    else $error("blink phase off period");
  a_flash_half: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(flash_ph) |-> flash_cnt == 25'h000_0000)
    else $error("flash phase off period");
  a_eth_nolink: assert property (@(posedge pclk) disable iff (!presetn)
    !eth_link[0] |=> !eth_led[0]) else $error("eth led lit without link");
  a_motor_green: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && !booting && motor_running[0] && !motor_ilimit[0] && !motor_short[0]
    && !motor_overload[0] && !supply_out_of_range && !supply_below_10v
    |=> motor_led[2:0] == msled_pkg::MSLED_GREEN) else $error("running not green");
  a_motor_limit: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && !booting && motor_running[0] && motor_ilimit[0] && !motor_short[0]
    && !motor_overload[0] && !supply_below_10v
    |=> motor_led[2:0] == msled_pkg::MSLED_RED) else $error("current limit not red");
  a_supply_red: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && !booting && supply_out_of_range && !motor_short[1]
    && !motor_overload[1] && !supply_below_10v
    |=> motor_led[5:3] == msled_pkg::MSLED_RED) else $error("supply range not red");
  a_motor_overload: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && !booting && motor_overload[0] && !motor_short[0] && !supply_below_10v
    |=> motor_led[2:0] == {1'b0, $past(blink_ph), 1'b0}) else $error("overload not blink red");
  a_motor_short: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && !booting && motor_short[1]
    |=> motor_led[5:3] == {1'b0, $past(flash_ph), 1'b0})
    else $error("short not flash red");
  a_motor_boot: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && booting |=> motor_led[2:0] == msled_pkg::MSLED_AMBER)
    else $error("boot not amber");
  a_motor_disc: assert property (@(posedge pclk) disable iff (!presetn)
    discovery |=> motor_led[2:0] == {1'b0, $past(slow_ph), 1'b0})
    else $error("discovery not slow red");
  a_status_ready: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && mstate == msled_pkg::MSLED_MS_READY
    |=> status_led == {2'b00, $past(blink_ph)}) else $error("ready not blink green");
  a_status_safe: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && mstate == msled_pkg::MSLED_MS_FAILSAFE |=> status_led[0] == $past(flash_ph))
    else $error("failsafe green not flashing");
  a_status_auto: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && mstate == msled_pkg::MSLED_MS_AUTOCFG
    |=> status_led == {1'b0, $past(flash_ph), 1'b0}) else $error("autocfg not flash red");
  a_status_peer: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && (mstate == msled_pkg::MSLED_MS_PEERLOST
    || mstate == msled_pkg::MSLED_MS_FWCHECK)
    |=> status_led == {1'b0, $past(blink_ph), $past(blink_ph)}) else $error("not blink amber");
  a_status_fw: assert property (@(posedge pclk) disable iff (!presetn)
    !discovery && mstate == msled_pkg::MSLED_MS_FWWRITE |=> status_led == msled_pkg::MSLED_AMBER)
    else $error("fw write not amber");
endmodule

// *** core/msled_params.svh ***
// Constants for the module status LED driver
`ifndef MSLED_PARAMS_SVH
`define MSLED_PARAMS_SVH
// Clock rate and cadence times
`define MSLED_CLK_HZ 50000000
`define MSLED_BLINK_MS 500
`define MSLED_FLASH_MS 250
`define MSLED_SLOW_MS 1000
// Half periods in cycles (one toggle per half cycle)
`define MSLED_BLINK_HALF ((`MSLED_CLK_HZ / 1000) * `MSLED_BLINK_MS / 2)
`define MSLED_FLASH_HALF ((`MSLED_CLK_HZ / 1000) * `MSLED_FLASH_MS / 2)
`define MSLED_SLOW_HALF ((`MSLED_CLK_HZ / 1000) * `MSLED_SLOW_MS / 2)
// Starting windows in milliseconds, per motor type
`define MSLED_START_ECO_MS 5000
`define MSLED_START_ECOP_MS 0
`define MSLED_START_HIGH_MS 1500
`define MSLED_START_MAX_MS 3000
`define MSLED_MS_CYCLES (`MSLED_CLK_HZ / 1000)
// Starting current limits in tenths of an ampere
`define MSLED_ILIM_ECO 8'h1E
`define MSLED_ILIM_ECOP 8'h29
`define MSLED_ILIM_HIGH 8'h32
`define MSLED_ILIM_MAX 8'h50
// Register byte offsets
`define MSLED_REG_CTRL 12'h000
`define MSLED_REG_MOTOR 12'h004
`define MSLED_REG_STATUS 12'h008
`define MSLED_REG_LEDS 12'h00C
// Control register fields; MT0 and MT1 sit in the motor register
`define MSLED_CTRL_MS_LSB 0
`define MSLED_CTRL_BOOT 3
`define MSLED_CTRL_DISC 4
`define MSLED_CTRL_MT0_LSB 8
`define MSLED_CTRL_MT1_LSB 10
`endif

// *** core/msled_pkg.sv ***
// Types for the module status LED driver
package msled_pkg;
  typedef enum logic [2:0] {
    MSLED_OFF = 3'b000,
    MSLED_GREEN = 3'b001,
    MSLED_RED = 3'b010,
    MSLED_AMBER = 3'b011
  } msled_colour_t;
  typedef enum logic [1:0] {
    MSLED_ECONOMY_MOTOR_TYPE = 2'b00,
    MSLED_ECONOMY_PLUS_MOTOR_TYPE = 2'b01,
    MSLED_HIGH_START_MOTOR_TYPE = 2'b10,
    MSLED_MAX_START_MOTOR_TYPE = 2'b11
  } msled_mtype_t;
  typedef enum logic [2:0] {
    MSLED_MS_TASKS = 3'b000,
    MSLED_MS_READY = 3'b001,
    MSLED_MS_FAILSAFE = 3'b010,
    MSLED_MS_AUTOCFG = 3'b011,
    MSLED_MS_PEERLOST = 3'b100,
    MSLED_MS_FWCHECK = 3'b101,
    MSLED_MS_FWWRITE = 3'b110
  } msled_mstate_t;
endpackage

// *** core/msled_start_window.sv ***
// Starting current window timer for one motor port
`timescale 1ns/1ps
`include "msled_params.svh"
module msled_start_window (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  input wire logic motor_start,
  input wire msled_pkg::msled_mtype_t mtype,
  output logic in_window,
  output logic [7:0] ilimit
);
  logic [12:0] ms_left;
  logic [12:0] next_ms_left;
  logic [7:0] next_ilimit;
  logic [12:0] win_ms;

  always_comb begin
    case (mtype)
      msled_pkg::MSLED_ECONOMY_MOTOR_TYPE: win_ms = 13'(`MSLED_START_ECO_MS);
      msled_pkg::MSLED_ECONOMY_PLUS_MOTOR_TYPE: win_ms = 13'(`MSLED_START_ECOP_MS);
      msled_pkg::MSLED_HIGH_START_MOTOR_TYPE: win_ms = 13'(`MSLED_START_HIGH_MS);
      default: win_ms = 13'(`MSLED_START_MAX_MS);
    endcase
  end

  // Constant type has no window, so the start load is zero
  always_comb begin
    next_ms_left = ms_left;
    if (motor_start) begin
      next_ms_left = win_ms;
    end else if (ms_tick && ms_left != 13'h0000) begin
      next_ms_left = ms_left - 13'h0001;
    end
    next_ilimit = `MSLED_ILIM_ECOP;
    case (mtype)
      msled_pkg::MSLED_ECONOMY_MOTOR_TYPE: next_ilimit = `MSLED_ILIM_ECO;
      msled_pkg::MSLED_ECONOMY_PLUS_MOTOR_TYPE: next_ilimit = `MSLED_ILIM_ECOP;
      msled_pkg::MSLED_HIGH_START_MOTOR_TYPE: next_ilimit = `MSLED_ILIM_HIGH;
      default: next_ilimit = `MSLED_ILIM_MAX;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_left <= 13'h0000;
      ilimit <= 8'h00;
    end else begin
      ms_left <= next_ms_left;
      ilimit <= next_ilimit;
    end
  end

  assign in_window = (ms_left != 13'h0000);

  a_start_load: assert property (@(posedge pclk) disable iff (!presetn)
    motor_start |=> ms_left == $past(win_ms)) else $error("window not loaded");
  a_start_none: assert property (@(posedge pclk) disable iff (!presetn)
    motor_start && mtype == msled_pkg::MSLED_ECONOMY_PLUS_MOTOR_TYPE |=> !in_window)
    else $error("constant type got a window");
  a_ilim_max: assert property (@(posedge pclk) disable iff (!presetn)
    mtype == msled_pkg::MSLED_MAX_START_MOTOR_TYPE |=> ilimit == `MSLED_ILIM_MAX)
    else $error("wrong current limit");
endmodule

// *** verification/msled_src_model.sv ***
// Model of the motor status sources behind each motor port
`timescale 1ns/1ps
module msled_src_model (
  input wire logic [2:0] cond0,
  input wire logic [2:0] cond1,
  output logic [1:0] motor_running,
  output logic [1:0] motor_ilimit,
  output logic [1:0] motor_disconnected,
  output logic [1:0] motor_overheat,
  output logic [1:0] motor_overload,
  output logic [1:0] motor_short
);
  // ********************
  // Condition decode
  // ********************
  // Codes: 0 stopped, 1 run, 2 run in limit, 3 unplugged, 4 hot, 5 overload, 6 short
  function automatic logic [5:0] decode(input logic [2:0] c);
    logic [5:0] v;
    v = 6'h00;
    // A limit, overload or short only occurs while turning
    v[0] = (c == 3'h1) || (c == 3'h2) || (c >= 3'h5);
    v[1] = (c == 3'h2);
    v[2] = (c == 3'h3);
    v[3] = (c == 3'h4);
    v[4] = (c == 3'h5);
    v[5] = (c == 3'h6);
    return v;
  endfunction
  always_comb begin
    logic [5:0] a;
    logic [5:0] b;
    a = decode(cond0);
    b = decode(cond1);
    motor_running = {b[0], a[0]};
    motor_ilimit = {b[1], a[1]};
    motor_disconnected = {b[2], a[2]};
    motor_overheat = {b[3], a[3]};
    motor_overload = {b[4], a[4]};
    motor_short = {b[5], a[5]};
  end
endmodule

// *** verification/testbench.sv ***
// Self-checking testbench for the status LED driver
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] eth_link, eth_activity, motor_start, eth_led, start_window;
  logic [1:0] mrun, mlim, mdis, mhot, movl, mshort;
  logic supply_out_of_range, supply_below_10v, err;
  logic [2:0] cond0, cond1, status_led;
  logic [5:0] motor_led;
  logic [15:0] start_ilimit;
  int n_mismatch = 0;
  int compares = 0;
  msled_src_model u_src (.cond0(cond0), .cond1(cond1), .motor_running(mrun),
    .motor_ilimit(mlim), .motor_disconnected(mdis), .motor_overheat(mhot),
    .motor_overload(movl), .motor_short(mshort));
  msled_driver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eth_link(eth_link), .eth_activity(eth_activity),
    .motor_running(mrun), .motor_start(motor_start), .motor_ilimit(mlim),
    .motor_disconnected(mdis), .motor_overheat(mhot), .motor_overload(movl),
    .motor_short(mshort), .supply_out_of_range(supply_out_of_range),
    .supply_below_10v(supply_below_10v), .eth_led(eth_led), .motor_led(motor_led),
    .status_led(status_led), .start_window(start_window), .start_ilimit(start_ilimit));
  // ********************
  // Shared tasks
  // ********************
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Read data stands through the access phase and is taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 10) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl reset", rd, 32'h0000_0008);
    chk("boot amber", {26'h0, motor_led}, {26'h0, msled_pkg::MSLED_AMBER,
      msled_pkg::MSLED_AMBER});
    chk("eth idle", {30'h0, eth_led}, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_motor();
    logic [2:0] exp [5];
    exp = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h2};
    apb(1'b1, 12'h000, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      cond0 <= 3'(i);
      cond1 <= 3'(4 - i);
      settle();
      chk("motor0", {29'h0, motor_led[2:0]}, {29'h0, exp[i]});
      chk("motor1", {29'h0, motor_led[5:3]}, {29'h0, exp[4 - i]});
    end
    cond0 <= 3'h1;
    supply_out_of_range <= 1'b1;
    settle();
    chk("supply red", {29'h0, motor_led[2:0]}, 32'h0000_0002);
    supply_out_of_range <= 1'b0;
    cond0 <= 3'h5;
    cond1 <= 3'h6;
    settle();
    // Blink and flash sit in their dark phase this early after reset
    chk("overload", {29'h0, motor_led[2:0]}, 32'h0000_0000);
    chk("short", {29'h0, motor_led[5:3]}, 32'h0000_0000);
    cond0 <= 3'h1;
    cond1 <= 3'h0;
    supply_below_10v <= 1'b1;
    settle();
    chk("under 10v", {29'h0, motor_led[2:0]}, 32'h0000_0000);
    supply_below_10v <= 1'b0;
    cond0 <= 3'h0;
    $display("test motor done");
  endtask
  task automatic t_eth();
    eth_link <= 2'b01;
    settle();
    chk("eth link", {30'h0, eth_led}, 32'h0000_0001);
    eth_link <= 2'b10;
    settle();
    chk("eth swap", {30'h0, eth_led}, 32'h0000_0002);
    $display("test eth done");
  endtask
  task automatic t_status();
    apb(1'b1, 12'h000, 32'h0000_0006);
    settle();
    chk("fw write", {29'h0, status_led}, 32'h0000_0003);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("leds reg", {29'h0, rd[10:8]}, 32'h0000_0003);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl back", rd, 32'h0000_0006);
    cond0 <= 3'h1;
    apb(1'b1, 12'h000, 32'h0000_0010);
    settle();
    chk("disc motor", {29'h0, motor_led[2:0]}, 32'h0000_0000);
    chk("disc status", {29'h0, status_led}, 32'h0000_0000);
    cond0 <= 3'h0;
    $display("test status done");
  endtask
  task automatic t_start();
    logic [1:0] ty [4];
    logic [7:0] lim [4];
    ty = '{2'h1, 2'h0, 2'h2, 2'h3};
    lim = '{8'h29, 8'h1E, 8'h32, 8'h50};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, {20'h0, ty[i], ty[i], 8'h00});
      motor_start <= 2'b11;
      @(posedge pclk);
      motor_start <= 2'b00;
      settle();
      chk("ilimit", {16'h0, start_ilimit}, {16'h0, lim[i], lim[i]});
      chk("window", {30'h0, start_window}, (i == 0) ? 32'h0 : 32'h3);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("status reg", rd, {16'h0, lim[i], lim[i]});
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("motor reg", rd, {20'h0, ty[i], ty[i], 8'h00});
    end
    $display("test start done");
  endtask
  task automatic t_rereset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("held leds", {26'h0, motor_led}, 32'h0000_0000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reboot amber", {29'h0, motor_led[5:3]}, 32'h0000_0003);
    chk("reboot window", {30'h0, start_window}, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("reboot ctrl", rd, 32'h0000_0008);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("reboot limit", rd, 32'h0000_1E1E);
    $display("test rereset done");
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("wr err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("rd err", {31'h0, err}, 32'h0000_0001);
    chk("rd zero", rd, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl kept", rd, 32'h0000_0008);
    $display("test unmapped done");
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {eth_link, eth_activity, motor_start} = 6'h00;
    {cond0, cond1} = 6'h00;
    {supply_out_of_range, supply_below_10v} = 2'b00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_motor();
    t_eth();
    t_status();
    t_start();
    t_rereset();
    t_unmapped();
    finish_test();
  end
endmodule
